// ### rtl/mfc_mode_feature_ctrl.sv
// Notes on behaviour
// - read preamble one or two clocks
// - read preamble training mode, one or two clocks
// - low temperature lets device skip refreshes
// - command captured programmed clocks after select
// - termination disabled means ignore power-down buffer bit
// - inversion shares byte pin, reads and writes
// - no read inversion during pattern register reads
// - byte mask acts on writes only
// - non-persistent mode stops checking while error set
// - buffer off in power-down drops nominal termination
// - parity error flag sticky until mode_reg_five write with its clear bit low
// - crc error flag sticky until mode_reg_five write with its clear bit low
// - parity checking enabled by nonzero latency
// - command with parity error is not executed
// - check bit covers strobes, address, bank bits
`timescale 1ns/1ps
`default_nettype none

module mfc_mode_feature_ctrl
    import mfc_pkg::*;
(
    input  wire logic      mclk,            // system clock, 50 MHz
    input  wire logic      rst_n,           // async reset, active low
    input  wire mfc_pins_t pinsIn,          // command pins incl. link clock
    input  wire logic      crcErrEvt,       // write crc mismatch, one cycle
    input  wire logic      mprReadActive,   // pattern register read running
    input  wire logic      powerDownActive, // device in power-down
    input  wire logic      lowTempSense,    // sensor reports low temperature
    output var  logic      cmdValid,        // executed command, one cycle
    output var  mfc_cmd_t  cmdOut,          // executed command bits
    output var  mfc_cfg_t  modeCfg,         // programmed feature settings
    output var  logic      parErrFlag,      // sticky parity error
    output var  logic      crcErrFlag,      // sticky crc error
    output var  logic      readInvertEn,    // invert read data on byte pin
    output var  logic      writeInvertEn,   // invert write data on byte pin
    output var  logic      writeMaskEn,     // byte pin masks write bytes
    output var  logic      nomTermActive,   // nominal termination applied
    output var  logic      termBufOn,       // termination input buffer on
    output var  logic      refreshIssue     // internal refresh, one cycle
);

    mfc_state_t s_q;
    mfc_state_t s_d;
    mfc_pins_t  pin;
    mfc_cmd_t   cmdNow;
    logic       linkEdge;
    logic       capture;
    logic       chkOn;
    logic       parBad;
    logic       modeWr;
    logic       refCmd;
    logic [2:0] sel;
    logic       parClr;
    logic       crcClr;

    // even parity over every bit of a command
    function automatic logic cmdParity(input mfc_cmd_t c);
        return ^c;
    endfunction : cmdParity

    ////////////////////////////////////////////////////////////////////////
    // pins cross into mclk; the link clock is sampled like any other pin
    mfc_pin_sync #(
        .WIDTH   ($bits(mfc_pins_t)),
        .RST_VAL (PINS_IDLE)
    ) u_sync (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .pinsIn  (pinsIn),
        .pinsOut (pin)
    );

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        s_d = s_q;
        s_d.ckPrev = pin.ck;
        s_d.cmdValid = 1'b0;
        s_d.refreshIssue = 1'b0;
        // odt and chip select stay out of the check
        cmdNow = '{actN: pin.actN, ras: pin.ras, cas: pin.cas, we: pin.we,
                   addr: pin.addr, ba: pin.ba, bg: pin.bg};
        linkEdge = pin.ck & ~s_q.ckPrev;
        capture = 1'b0;
        // with a delay set, the command follows select by that many edges
        if (linkEdge) begin
            if (s_q.calCnt != '0) begin
                s_d.calCnt = s_q.calCnt - 3'h1;
                capture = (s_q.calCnt == 3'h1);
            end else if (!pin.csN) begin
                if (s_q.cfg.calCode == '0) begin
                    capture = 1'b1;
                end else begin
                    s_d.calCnt = s_q.cfg.calCode;
                end
            end
        end
        // a zero latency keeps checking off; a set flag pauses it unless
        // persistent mode is on
        chkOn = (s_q.cfg.parLat != '0)
                && (s_q.cfg.parPersist || !s_q.parErr);
        parBad = chkOn && (cmdParity(cmdNow) != pin.par);
        modeWr = capture && !parBad
                 && ({cmdNow.actN, cmdNow.ras, cmdNow.cas, cmdNow.we} == OP_MODE_WRITE);
        refCmd = capture && !parBad
                 && ({cmdNow.actN, cmdNow.ras, cmdNow.cas, cmdNow.we} == OP_REFRESH);
        sel = {cmdNow.bg, cmdNow.ba};
        parClr = modeWr && (sel == SEL_MR5) && !cmdNow.addr[MR5_PARCLR_BIT];
        crcClr = modeWr && (sel == SEL_MR5) && !cmdNow.addr[MR5_CRCCLR_BIT];
        // a failing command is dropped and only raises the flag
        if (capture) begin
            if (parBad) begin
                s_d.parErr = 1'b1;
            end else begin
                s_d.cmdValid = 1'b1;
                s_d.cmd = cmdNow;
            end
        end
        if (modeWr) begin
            unique case (sel)
                SEL_MR1: begin
                    s_d.cfg.rttNom = cmdNow.addr[MR1_RTTNOM_LSB +: RTTNOM_W];
                end
                SEL_MR4: begin
                    s_d.cfg.wrPre2 = cmdNow.addr[MR4_WPRE_BIT];
                    s_d.cfg.rdPre2 = cmdNow.addr[MR4_RPRE_BIT];
                    s_d.cfg.rdPreTrain = cmdNow.addr[MR4_RPTRN_BIT];
                    s_d.cfg.tcrEn = cmdNow.addr[MR4_TCR_BIT];
                    s_d.cfg.calCode = cmdNow.addr[MR4_CAL_LSB +: CAL_W];
                    s_d.cfg.vrefMonEn = cmdNow.addr[MR4_VMON_BIT];
                end
                SEL_MR5: begin
                    s_d.cfg.parLat = cmdNow.addr[MR5_PL_LSB +: PL_W];
                    s_d.cfg.parPersist = cmdNow.addr[MR5_PERS_BIT];
                    s_d.cfg.dmEn = cmdNow.addr[MR5_DM_BIT];
                    s_d.cfg.wDbiEn = cmdNow.addr[MR5_WDBI_BIT];
                    s_d.cfg.rDbiEn = cmdNow.addr[MR5_RDBI_BIT];
                    // bit is meaningless while nominal termination is off
                    if (s_q.cfg.rttNom != '0) begin
                        s_d.cfg.odtBufPdOn = cmdNow.addr[MR5_ODTPD_BIT];
                    end
                end
                SEL_MR6: begin
                    s_d.cfg.mr6 = {cmdNow.ras, cmdNow.cas, cmdNow.we,
                                   cmdNow.addr};
                end
                default: begin
                end
            endcase
        end
        // flags clear only by a passing mode write; a new error wins
        if (parClr) begin
            s_d.parErr = 1'b0;
        end
        if (crcClr) begin
            s_d.crcErr = 1'b0;
        end
        if (crcErrEvt) begin
            s_d.crcErr = 1'b1;
        end
        // when cold, the first of each pair of refreshes is skipped (2:1 stretch)
        if (refCmd) begin
            if (s_q.cfg.tcrEn && lowTempSense) begin
                s_d.refSkip = ~s_q.refSkip;
                s_d.refreshIssue = s_q.refSkip;
            end else begin
                s_d.refSkip = 1'b0;
                s_d.refreshIssue = 1'b1;
            end
        end
        // byte pin use, from the new settings
        s_d.readInv = s_d.cfg.rDbiEn && !mprReadActive;
        s_d.writeInv = s_d.cfg.wDbiEn;
        s_d.writeMask = s_d.cfg.dmEn;
        // a floating pin in power-down must not turn termination on
        s_d.termBufOn = !powerDownActive || s_d.cfg.odtBufPdOn;
        s_d.nomTerm = (s_d.cfg.rttNom != '0) && pin.termination_ctrl_pin
                      && s_d.termBufOn;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{cfg: CFG_RST, cmd: '0, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign cmdValid      = s_q.cmdValid;
    assign cmdOut        = s_q.cmd;
    assign modeCfg       = s_q.cfg;
    assign parErrFlag    = s_q.parErr;
    assign crcErrFlag    = s_q.crcErr;
    assign readInvertEn  = s_q.readInv;
    assign writeInvertEn = s_q.writeInv;
    assign writeMaskEn   = s_q.writeMask;
    assign nomTermActive = s_q.nomTerm;
    assign termBufOn     = s_q.termBufOn;
    assign refreshIssue  = s_q.refreshIssue;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_par_sticky;
        s_q.parErr && !parClr |=> s_q.parErr;
    endproperty
    a_par_sticky: assert property (p_par_sticky)
        else $error("parity flag dropped without a clearing write");

    property p_crc_set;
        crcErrEvt |=> s_q.crcErr ##1 (s_q.crcErr || $past(crcClr));
    endproperty
    a_crc_set: assert property (p_crc_set)
        else $error("crc flag not set or not held");

    property p_par_off;
        capture && (s_q.cfg.parLat == '0)
            |=> cmdValid && (parErrFlag == $past(s_q.parErr && !parClr));
    endproperty
    a_par_off: assert property (p_par_off)
        else $error("command blocked while parity is disabled");

    property p_par_block;
        capture && parBad |=> !cmdValid && parErrFlag;
    endproperty
    a_par_block: assert property (p_par_block)
        else $error("command with bad parity was executed");

    property p_nonpersist;
        capture && s_q.parErr && !s_q.cfg.parPersist |=> cmdValid;
    endproperty
    a_nonpersist: assert property (p_nonpersist)
        else $error("checking continued with flag set in normal mode");

    property p_mpr_noinv;
        mprReadActive |=> !readInvertEn;
    endproperty
    a_mpr_noinv: assert property (p_mpr_noinv)
        else $error("read data inverted during pattern read");

    property p_mr6_write;
        modeWr && (sel == SEL_MR6) |=> modeCfg.mr6 == {$past(cmdNow.ras),
            $past(cmdNow.cas), $past(cmdNow.we), $past(cmdNow.addr)};
    endproperty
    a_mr6_write: assert property (p_mr6_write)
        else $error("mode_reg_six not updated from address");

    property p_odt_ignore;
        modeWr && (sel == SEL_MR5) && (s_q.cfg.rttNom == '0) |=> $stable(modeCfg.odtBufPdOn);
    endproperty
    a_odt_ignore: assert property (p_odt_ignore)
        else $error("power-down buffer bit taken with termination off");

    property p_pd_buf;
        powerDownActive && !s_d.cfg.odtBufPdOn |=> !termBufOn && !nomTermActive;
    endproperty
    a_pd_buf: assert property (p_pd_buf)
        else $error("termination active with buffer off in power-down");

    property p_cal_hold;
        linkEdge && !pin.csN && (s_q.calCnt == '0) && (s_q.cfg.calCode != '0)
            |-> !capture ##1 (s_q.calCnt == $past(s_q.cfg.calCode));
    endproperty
    a_cal_hold: assert property (p_cal_hold)
        else $error("command taken before programmed delay");

    property p_ref_skip;
        refCmd && s_q.cfg.tcrEn && lowTempSense |=> refreshIssue == $past(s_q.refSkip);
    endproperty
    a_ref_skip: assert property (p_ref_skip)
        else $error("cold refresh not alternating");

    property p_mask_wr;
        modeWr && (sel == SEL_MR5) |=> writeMaskEn == $past(cmdNow.addr[MR5_DM_BIT]);
    endproperty
    a_mask_wr: assert property (p_mask_wr)
        else $error("byte mask enable does not follow its setting");

    property p_winv_wr;
        modeWr && (sel == SEL_MR5) |=> writeInvertEn == $past(cmdNow.addr[MR5_WDBI_BIT]);
    endproperty
    a_winv_wr: assert property (p_winv_wr)
        else $error("write inversion enable does not follow its setting");

    c_mode_write: cover property (modeWr && (sel == SEL_MR5));
    c_par_err:    cover property (capture && parBad);
    c_cal_cmd:    cover property (capture && (s_q.cfg.calCode != '0));
    c_ref_skip:   cover property (refCmd && s_q.cfg.tcrEn && lowTempSense);

endmodule : mfc_mode_feature_ctrl

`default_nettype wire

// ### include/mfc_pkg.sv
package mfc_pkg;

    // address pins carried by a command
    localparam int ADDR_W = 14;

    // command opcodes on {actN, ras, cas, we}
    localparam logic [3:0] OP_MODE_WRITE = 4'h8;
    localparam logic [3:0] OP_REFRESH    = 4'h9;

    // mode register select on {bg, ba}
    localparam logic [2:0] SEL_MR1 = 3'h1;
    localparam logic [2:0] SEL_MR4 = 3'h4;
    localparam logic [2:0] SEL_MR5 = 3'h5;
    localparam logic [2:0] SEL_MR6 = 3'h6;

    // mode_reg_one fields
    localparam int MR1_RTTNOM_LSB = 8;
    localparam int RTTNOM_W       = 3;

    // mode_reg_four fields
    localparam int MR4_TCR_BIT    = 3;
    localparam int MR4_VMON_BIT   = 4;
    localparam int MR4_CAL_LSB    = 6;
    localparam int CAL_W          = 3;
    localparam int MR4_RPTRN_BIT  = 10;
    localparam int MR4_RPRE_BIT   = 11;
    localparam int MR4_WPRE_BIT   = 12;

    // mode_reg_five fields
    localparam int MR5_PL_LSB     = 0;
    localparam int PL_W           = 3;
    localparam int MR5_CRCCLR_BIT = 3;
    localparam int MR5_PARCLR_BIT = 4;
    localparam int MR5_ODTPD_BIT  = 5;
    localparam int MR5_PERS_BIT   = 9;
    localparam int MR5_DM_BIT     = 10;
    localparam int MR5_WDBI_BIT   = 11;
    localparam int MR5_RDBI_BIT   = 12;

    // mode_reg_six stores the strobe/address pins A16..A0
    localparam int MR6_W = 17;

    // pins as seen after the synchroniser
    typedef struct packed {
        logic              ck;
        logic              csN;
        logic              actN;
        logic              ras;
        logic              cas;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [1:0]        ba;
        logic              bg;
        logic              par;
        logic              termination_ctrl_pin;
    } mfc_pins_t;

    // pins idle: chip select and activate high
    localparam mfc_pins_t PINS_IDLE = '{csN: 1'b1, actN: 1'b1, default: '0};

    // a captured command, exactly the bits covered by the check bit
    typedef struct packed {
        logic              actN;
        logic              ras;
        logic              cas;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [1:0]        ba;
        logic              bg;
    } mfc_cmd_t;

    // programmed feature settings
    typedef struct packed {
        logic                wrPre2;
        logic                rdPre2;
        logic                rdPreTrain;
        logic                tcrEn;
        logic [CAL_W-1:0]    calCode;
        logic                vrefMonEn;
        logic [PL_W-1:0]     parLat;
        logic                parPersist;
        logic                dmEn;
        logic                wDbiEn;
        logic                rDbiEn;
        logic                odtBufPdOn;
        logic [RTTNOM_W-1:0] rttNom;
        logic [MR6_W-1:0]    mr6;
    } mfc_cfg_t;

    localparam mfc_cfg_t CFG_RST = '0;

    // whole state of the main module
    typedef struct packed {
        logic             ckPrev;
        mfc_cfg_t         cfg;
        logic [CAL_W-1:0] calCnt;
        logic             parErr;
        logic             crcErr;
        logic             cmdValid;
        mfc_cmd_t         cmd;
        logic             readInv;
        logic             writeInv;
        logic             writeMask;
        logic             nomTerm;
        logic             termBufOn;
        logic             refSkip;
        logic             refreshIssue;
    } mfc_state_t;

endpackage : mfc_pkg

// ### rtl/mfc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module mfc_pin_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             mclk,    // system clock
    input  wire logic             rst_n,   // async reset, active low
    input  wire logic [WIDTH-1:0] pinsIn,  // raw pins
    output var  logic [WIDTH-1:0] pinsOut  // pins after two flops
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } mfc_sync_t;

    mfc_sync_t s_q;
    mfc_sync_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // first stage feeds only the second stage
    always_comb begin
        s_d    = s_q;
        s_d.s1 = pinsIn;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{s1: RST_VAL, s2: RST_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    assign pinsOut = s_q.s2;

endmodule : mfc_pin_sync

`default_nettype wire

// ### tb/mfc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module mfc_ctrl_model
    import mfc_pkg::*;
(
    input  wire logic      mclk,    // bench clock, paces the link
    input  wire logic      odtLvl,  // termination level held by the controller
    output var  mfc_pins_t pins     // command pins toward the device
);
    // link clock high time in mclk cycles: 80 ns; the low phase runs longer, so a link period of 180 ns or more
    localparam int HALF = 4;

    mfc_pins_t drv;

    initial drv = PINS_IDLE;

    // termination pin is always held at a valid level, also in power-down
    always_comb begin
        pins     = drv;
        pins.termination_ctrl_pin = odtLvl;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one link clock pulse around a pin set; the link clock stands low between frames
    task automatic frame(input mfc_pins_t p);
        mfc_pins_t q;
        q     = ~p;
        q.ck  = 1'h0;
        q.csN = 1'h1;
        @(negedge mclk);
        drv = p;
        repeat (HALF) @(negedge mclk);
        drv.ck = 1'h1;
        repeat (HALF) @(negedge mclk);
        // released pins show the inverse, so stale bits never pass for valid ones
        drv = q;
    endtask : frame

    // command with an optional select-to-command delay in whole link clocks
    task automatic send(input mfc_cmd_t c, input int cal, input logic bad);
        mfc_pins_t p;
        p = PINS_IDLE;
        if (cal > 0) begin
            p.csN          = 1'h0;
            p.addr         = ~c.addr;
            {p.bg, p.ba}   = ~{c.bg, c.ba};
            frame(p);
            p.csN = 1'h1;
            for (int i = 1; i < cal; i++) begin
                frame(p);
            end
        end
        {p.actN, p.ras, p.cas, p.we, p.addr, p.ba, p.bg} = c;
        p.csN = (cal > 0);
        p.par = (^c) ^ bad; // even parity over strobes, address and bank bits
        frame(p);
        repeat (HALF) @(negedge mclk);
    endtask : send

endmodule : mfc_ctrl_model

`default_nettype wire

// ### tb/sdram_mode_feature_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module sdram_mode_feature_control_bench
    import mfc_pkg::*;
;
    logic      mclk = 1'h0, rst_n = 1'h0, crcErrEvt = 1'h0, odtLvl = 1'h0;
    logic      mprReadActive = 1'h0, powerDownActive = 1'h0, lowTempSense = 1'h0;
    mfc_pins_t pins;
    logic      cmdValid, parErrFlag, crcErrFlag, readInvertEn, writeInvertEn;
    logic      writeMaskEn, nomTermActive, termBufOn, refreshIssue;
    mfc_cmd_t  cmdOut;
    mfc_cfg_t  modeCfg;
    int        errCount = 0, compares = 0, vCnt = 0, rCnt = 0;

    always #10 mclk = ~mclk;

    mfc_ctrl_model ctl (.mclk(mclk), .odtLvl(odtLvl), .pins(pins));

    mfc_mode_feature_ctrl dut (
        .mclk(mclk), .rst_n(rst_n), .pinsIn(pins), .crcErrEvt(crcErrEvt),
        .mprReadActive(mprReadActive), .powerDownActive(powerDownActive),
        .lowTempSense(lowTempSense), .cmdValid(cmdValid), .cmdOut(cmdOut),
        .modeCfg(modeCfg), .parErrFlag(parErrFlag), .crcErrFlag(crcErrFlag),
        .readInvertEn(readInvertEn), .writeInvertEn(writeInvertEn),
        .writeMaskEn(writeMaskEn), .nomTermActive(nomTermActive),
        .termBufOn(termBufOn), .refreshIssue(refreshIssue));

    // pulse outputs stand one cycle, so they are counted where they appear
    always @(negedge mclk) begin
        if (cmdValid === 1'h1) vCnt <= vCnt + 1;
        if (refreshIssue === 1'h1) rCnt <= rCnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stopTest();
        if (errCount == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stopTest

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    function automatic mfc_cmd_t mk(input logic [3:0] op, input logic [2:0] sel,
                                    input logic [ADDR_W-1:0] a);
        mfc_cmd_t c;
        {c.actN, c.ras, c.cas, c.we} = op;
        c.addr       = a;
        {c.bg, c.ba} = sel;
        return c;
    endfunction : mk

    // reserved bits are always written as zero
    task automatic mw(input logic [2:0] sel, input logic [ADDR_W-1:0] a, input logic bad);
        ctl.send(mk(OP_MODE_WRITE, sel, a), 0, bad);
    endtask : mw

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(modeCfg, CFG_RST);
        chk({parErrFlag, crcErrFlag, cmdValid}, 3'h0);
    endtask : t_reset

    task automatic t_mode();
        int v;
        v = vCnt;
        // two-clock write preamble; the matching write latency is the controller's duty
        mw(SEL_MR4, 14'h1C18, 1'h0);
        chk(modeCfg.wrPre2, 1'h1);
        chk(modeCfg.rdPre2, 1'h1);
        chk(modeCfg.rdPreTrain, 1'h1);
        chk({modeCfg.tcrEn, modeCfg.vrefMonEn}, 2'h3);
        // column gap code 001 for the middle rate band
        mw(SEL_MR6, 14'h04C5, 1'h0);
        chk(modeCfg.mr6, 17'h004C5);
        chk(cmdOut, mk(OP_MODE_WRITE, SEL_MR6, 14'h04C5));
        chk(vCnt, v + 2);
    endtask : t_mode

    task automatic t_refresh();
        int r;
        r = rCnt;
        @(negedge mclk) lowTempSense = 1'h1;
        repeat (2) ctl.send(mk(OP_REFRESH, 3'h0, 14'h0000), 0, 1'h0);
        chk(rCnt, r + 1);
        @(negedge mclk) lowTempSense = 1'h0;
        repeat (2) ctl.send(mk(OP_REFRESH, 3'h0, 14'h0000), 0, 1'h0);
        chk(rCnt, r + 3);
    endtask : t_refresh

    task automatic t_parity();
        int v;
        v = vCnt;
        mw(3'h2, 14'h0000, 1'h1);
        chk({vCnt, parErrFlag}, {v + 1, 1'h0});
        mw(SEL_MR5, 14'h0019, 1'h0);
        mw(3'h2, 14'h0000, 1'h1);
        chk({vCnt, parErrFlag}, {v + 2, 1'h1});
        mw(3'h2, 14'h0000, 1'h1);
        chk({vCnt, parErrFlag}, {v + 3, 1'h1});
        mw(SEL_MR5, 14'h0219, 1'h0);
        mw(SEL_MR5, 14'h0000, 1'h1);
        chk({modeCfg.parPersist, modeCfg.parLat, vCnt}, {1'h1, 3'h1, v + 4});
        mw(SEL_MR5, 14'h0008, 1'h0);
        chk(parErrFlag, 1'h0);
    endtask : t_parity

    task automatic t_crc();
        @(negedge mclk) crcErrEvt = 1'h1;
        @(negedge mclk) crcErrEvt = 1'h0;
        chk(crcErrFlag, 1'h1);
        mw(SEL_MR5, 14'h0018, 1'h0);
        mw(3'h2, 14'h0000, 1'h0);
        chk(crcErrFlag, 1'h1);
        mw(SEL_MR5, 14'h0010, 1'h0);
        chk(crcErrFlag, 1'h0);
    endtask : t_crc

    // mask and write inversion are never enabled together
    task automatic t_dbi();
        mw(SEL_MR5, 14'h1418, 1'h0);
        chk({writeMaskEn, writeInvertEn}, 2'h2);
        chk(readInvertEn, 1'h1);
        @(negedge mclk) mprReadActive = 1'h1;
        repeat (2) @(negedge mclk);
        chk(readInvertEn, 1'h0);
        mprReadActive = 1'h0;
        mw(SEL_MR5, 14'h1818, 1'h0);
        chk({writeInvertEn, writeMaskEn, readInvertEn}, 3'h5);
    endtask : t_dbi

    task automatic t_odt();
        mw(SEL_MR1, 14'h0000, 1'h0);
        mw(SEL_MR5, 14'h0038, 1'h0);
        @(negedge mclk);
        powerDownActive = 1'h1;
        odtLvl          = 1'h1;
        repeat (4) @(negedge mclk);
        chk({termBufOn, nomTermActive}, 2'h0);
        mw(SEL_MR1, 14'h0100, 1'h0);
        chk({termBufOn, nomTermActive}, 2'h0);
        mw(SEL_MR5, 14'h0038, 1'h0);
        chk({termBufOn, nomTermActive}, 2'h3);
        mw(SEL_MR5, 14'h0018, 1'h0);
        chk({termBufOn, nomTermActive}, 2'h0);
        @(negedge mclk) powerDownActive = 1'h0;
        repeat (2) @(negedge mclk);
        chk({termBufOn, nomTermActive}, 2'h3);
    endtask : t_odt

    task automatic t_cal();
        int v;
        mw(SEL_MR4, 14'h0088, 1'h0);
        chk(modeCfg.calCode, 3'h2);
        v = vCnt;
        ctl.send(mk(OP_MODE_WRITE, SEL_MR6, 14'h0800), 2, 1'h0);
        chk({modeCfg.mr6, modeCfg.rttNom}, {17'h00800, 3'h1});
        chk(vCnt, v + 1);
        ctl.send(mk(OP_MODE_WRITE, SEL_MR4, 14'h0000), 2, 1'h0);
        chk(modeCfg.calCode, 3'h0);
    endtask : t_cal

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence; the link clock stays low until well after reset release
    initial begin
        repeat (5) @(posedge mclk);
        @(negedge mclk) rst_n = 1'h1;
        repeat (3) @(negedge mclk);
        t_reset();
        t_mode();
        t_refresh();
        t_parity();
        t_crc();
        t_dbi();
        t_odt();
        t_cal();
        stopTest();
    end

    // about thirty link frames, some 8 us in all; the 200 us limit is over twenty times that
    initial begin
        #200us;
        errCount++;
        stopTest();
    end

endmodule : sdram_mode_feature_control_bench

`default_nettype wire
